//--- inc/fdc_cmd_pkg.sv
// constants, types and enums for the recalibrate, relative seek and scan command block
package fdc_cmd_pkg;
   localparam logic [7:0]  OPC_RECAL       = 8'h07;
   localparam logic [7:0]  OPC_RSEEK_MASK  = 8'hBF;
   localparam logic [7:0]  OPC_RSEEK       = 8'h8F;
   localparam logic [7:0]  OPC_SCAN_MASK   = 8'h1F;
   localparam logic [7:0]  OPC_SCAN_EQ     = 8'h11;
   localparam logic [7:0]  OPC_SCAN_LE     = 8'h19;
   localparam logic [7:0]  OPC_SCAN_HE     = 8'h1D;
   localparam int          BIT_RSEEK_DIR   = 6;
   localparam int          BIT_HEAD_SEL    = 2;
   localparam int          BIT_LONG_COUNT  = 0;
   localparam int          BIT_EXT_RANGE   = 4;
   localparam int          BIT_WILDCARD    = 4;
   localparam int          ST2_SATISFIED   = 3;
   localparam int          ST2_NOT_SAT     = 2;
   localparam logic [11:0] RECAL_MAX_DEF   = 12'h055;
   localparam logic [11:0] RECAL_MAX_LONG  = 12'h0FF;
   localparam logic [11:0] RECAL_MAX_EXT   = 12'hF55;
   localparam logic [11:0] RECAL_MAX_BOTH  = 12'hFFF;
   localparam logic [3:0]  LEN_RECAL       = 4'h2;
   localparam logic [3:0]  LEN_RSEEK       = 4'h3;
   localparam logic [3:0]  LEN_SCAN        = 4'h9;
   localparam logic [3:0]  IDX_DRIVE       = 4'h2;
   localparam logic [3:0]  IDX_RTN         = 4'h3;
   localparam logic [3:0]  IDX_SECTOR      = 4'h5;
   localparam logic [3:0]  IDX_LAST_SECTOR = 4'h7;
   localparam logic [3:0]  IDX_GAP         = 4'h8;
   localparam logic [3:0]  IDX_STEP_SIZE   = 4'h9;
   localparam logic [7:0]  WILDCARD_BYTE   = 8'hFF;

   typedef enum logic [2:0] {
      CMD_NONE    = 3'b000,
      CMD_RECAL   = 3'b001,
      CMD_RSEEK   = 3'b010,
      CMD_SCAN_EQ = 3'b011,
      CMD_SCAN_LE = 3'b100,
      CMD_SCAN_HE = 3'b101
   } cmdKind_t;

   typedef enum logic [1:0] {
      PH_IDLE    = 2'b00,
      PH_COLLECT = 2'b01,
      PH_DELAY   = 2'b10,
      PH_SCAN    = 2'b11
   } phase_t;

   typedef struct packed {
      logic [7:0] diskByte;
      logic [7:0] hostByte;
      logic       valid;
      logic       lastOfSector;
   } scanByte_t;

   typedef struct packed {
      logic       step;
      logic       dirIn;
      logic [1:0] driveSel;
      logic       headSel;
   } driveIf_t;
endpackage

//--- core/fdc_recal_seek_scan_cmds.sv
// command interpreter for recalibrate, relative seek and the three scan commands
`timescale 1ns/1ps
module fdc_recal_seek_scan_cmds (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             cmdByte,
   input  wire logic                   cmdWrite,
   input  wire logic [7:0]             modeParam2,
   input  wire logic [7:0]             modeParam3,
   input  wire logic [7:0]             modeParam4,
   input  wire logic [15:0]            delayCycles,
   input  wire logic [7:0]             stepCycles,
   input  wire logic                   pollPhase,
   input  wire logic                   trackZeroInput,
   input  wire logic                   senseIntAck,
   input  wire fdc_cmd_pkg::scanByte_t scanIn,
   input  wire logic                   transferTerminalCount,
   output fdc_cmd_pkg::driveIf_t       driveIf,
   output logic [3:0]                  mainStatusBusy,
   output logic                        cmdBusy,
   output logic                        intPending,
   output logic [11:0]                 presentTrack,
   output logic [7:0]                  resultStatusTwo,
   output logic                        scanDone,
   output logic [7:0]                  nextSector,
   output logic [7:0]                  gapLength
);
   import fdc_cmd_pkg::*;

   phase_t      phase,       next_phase;
   cmdKind_t    kind,        next_kind;
   logic [3:0]  count,       next_count;
   logic [15:0] delayTimer,  next_delayTimer;
   logic        stepActive,  next_stepActive;
   logic        isRecal,     next_isRecal;
   logic [11:0] stepRemain,  next_stepRemain;
   logic [7:0]  stepTimer,   next_stepTimer;
   logic [11:0] track [4];
   logic [11:0] next_track [4];
   logic [7:0]  lastSector,  next_lastSector;
   logic [7:0]  stepSize,    next_stepSize;
   logic        decided,     next_decided;
   logic        diskHigher,  next_diskHigher;
   logic [7:0]  sectorSt2,   next_sectorSt2;
   driveIf_t    next_driveIf;
   logic [3:0]  next_mainStatusBusy;
   logic        next_intPending;
   logic [7:0]  next_resultStatusTwo;
   logic        next_scanDone;
   logic [7:0]  next_nextSector;
   logic [7:0]  next_gapLength;
   logic [3:0]  cmdLen;
   logic [11:0] recalMax;
   logic        byteDiffers;
   logic        lastDecided;
   logic        lastHigher;
   logic        sectorMatch;
   logic        stepEnd;
   logic        intSet;

   always_comb
   begin
      case (kind)
         CMD_RECAL: cmdLen = LEN_RECAL;
         CMD_RSEEK: cmdLen = LEN_RSEEK;
         default:   cmdLen = LEN_SCAN;
      endcase
   end

   always_comb
   begin
      case ({modeParam2[BIT_LONG_COUNT], modeParam3[BIT_EXT_RANGE]})
         2'b00:   recalMax = RECAL_MAX_DEF;
         2'b10:   recalMax = RECAL_MAX_LONG;
         2'b01:   recalMax = RECAL_MAX_EXT;
         default: recalMax = RECAL_MAX_BOTH;
      endcase
   end

   assign byteDiffers = (scanIn.diskByte != scanIn.hostByte) &&
                        !(modeParam4[BIT_WILDCARD] && (scanIn.diskByte == WILDCARD_BYTE ||
                                                       scanIn.hostByte == WILDCARD_BYTE));
   // most significant byte first, so the first differing byte decides the sector
   assign lastDecided = decided || byteDiffers;
   assign lastHigher  = decided ? diskHigher : (scanIn.diskByte > scanIn.hostByte);

   always_comb
   begin
      case (kind)
         CMD_SCAN_LE: sectorMatch = !lastDecided || !lastHigher;
         CMD_SCAN_HE: sectorMatch = !lastDecided || lastHigher;
         default:     sectorMatch = !lastDecided;
      endcase
   end

   assign stepEnd = stepActive && (trackZeroInput || (stepRemain == 12'h000 &&
                                                      stepTimer == 8'h00));
   assign intSet = stepEnd;

   always_comb
   begin
      next_phase           = phase;
      next_kind            = kind;
      next_count           = count;
      next_delayTimer      = delayTimer;
      next_stepActive      = stepActive;
      next_isRecal         = isRecal;
      next_stepRemain      = stepRemain;
      next_stepTimer       = stepTimer;
      next_track           = track;
      next_lastSector      = lastSector;
      next_stepSize        = stepSize;
      next_decided         = decided;
      next_diskHigher      = diskHigher;
      next_sectorSt2       = sectorSt2;
      next_driveIf         = driveIf;
      next_driveIf.step    = 1'b0;
      next_mainStatusBusy  = mainStatusBusy;
      next_resultStatusTwo = resultStatusTwo;
      next_scanDone        = 1'b0;
      next_nextSector      = nextSector;
      next_gapLength       = gapLength;
      case (phase)
         PH_IDLE:
         begin
            if (cmdWrite)
            begin
               next_count = 4'h1;
               next_phase = PH_COLLECT;
               if (cmdByte == OPC_RECAL)
                  next_kind = CMD_RECAL;
               else if ((cmdByte & OPC_RSEEK_MASK) == OPC_RSEEK)
                  next_kind = CMD_RSEEK;
               else if ((cmdByte & OPC_SCAN_MASK) == OPC_SCAN_EQ)
                  next_kind = CMD_SCAN_EQ;
               else if ((cmdByte & OPC_SCAN_MASK) == OPC_SCAN_LE)
                  next_kind = CMD_SCAN_LE;
               else if ((cmdByte & OPC_SCAN_MASK) == OPC_SCAN_HE)
                  next_kind = CMD_SCAN_HE;
               else
               begin
                  next_kind  = CMD_NONE;
                  next_phase = PH_IDLE;
               end
            end
         end
         PH_COLLECT:
         begin
            if (cmdWrite)
            begin
               next_count = count + 4'h1;
               if (next_count == IDX_DRIVE)
               begin
                  next_driveIf.driveSel = cmdByte[1:0];
                  next_driveIf.headSel  = cmdByte[BIT_HEAD_SEL];
               end
               if (next_count == IDX_RTN && kind == CMD_RSEEK)
                  next_stepRemain = {4'h0, cmdByte};
               if (next_count == IDX_SECTOR)
                  next_nextSector = cmdByte;
               if (next_count == IDX_LAST_SECTOR)
                  next_lastSector = cmdByte;
               if (next_count == IDX_GAP)
                  next_gapLength = cmdByte;
               if (next_count == IDX_STEP_SIZE)
                  next_stepSize = cmdByte;
               if (next_count == cmdLen)
               begin
                  if (kind == CMD_RECAL || kind == CMD_RSEEK)
                  begin
                     next_mainStatusBusy[next_driveIf.driveSel] = 1'b1;
                     next_delayTimer = delayCycles;
                     next_isRecal    = (kind == CMD_RECAL);
                     next_phase      = PH_DELAY;
                     if (kind == CMD_RECAL)
                        next_stepRemain = recalMax;
                  end
                  else
                  begin
                     next_decided   = 1'b0;
                     next_sectorSt2 = 8'h00;
                     next_phase     = PH_SCAN;
                  end
               end
            end
         end
         PH_DELAY:
         begin
            if (delayTimer == 16'h0000)
            begin
               next_phase      = PH_IDLE;
               next_stepActive = 1'b1;
               next_stepTimer  = stepCycles;
            end
            else
               next_delayTimer = delayTimer - 16'h0001;
         end
         PH_SCAN:
         begin
            if (scanIn.valid)
            begin
               next_decided    = lastDecided;
               next_diskHigher = lastHigher;
            end
            if (scanIn.valid && scanIn.lastOfSector)
            begin
               next_sectorSt2                = 8'h00;
               next_sectorSt2[ST2_SATISFIED] = !lastDecided;
               next_sectorSt2[ST2_NOT_SAT]   = !sectorMatch;
               next_decided                  = 1'b0;
               next_nextSector               = nextSector + stepSize;
            end
            if (transferTerminalCount || (scanIn.valid && scanIn.lastOfSector &&
                                          (sectorMatch || nextSector == lastSector)))
            begin
               next_phase           = PH_IDLE;
               next_scanDone        = 1'b1;
               next_resultStatusTwo = next_sectorSt2;
            end
         end
         default: next_phase = PH_IDLE;
      endcase

      // stepping runs in the background while the phase machine is idle again
      if (stepEnd)
      begin
         next_stepActive = 1'b0;
         next_mainStatusBusy[driveIf.driveSel] = 1'b0;
         if (trackZeroInput && isRecal)
            next_track[driveIf.driveSel] = 12'h000;
      end
      else if (stepActive && pollPhase)
      begin
         if (stepTimer == 8'h00)
         begin
            if (stepRemain != 12'h000)
            begin
               next_driveIf.step = 1'b1;
               next_stepRemain   = stepRemain - 12'h001;
               if (driveIf.dirIn)
                  next_track[driveIf.driveSel] = track[driveIf.driveSel] + 12'h001;
               else if (track[driveIf.driveSel] != 12'h000)
                  next_track[driveIf.driveSel] = track[driveIf.driveSel] - 12'h001;
            end
            next_stepTimer = stepCycles;
         end
         else
            next_stepTimer = stepTimer - 8'h01;
      end

      if (phase == PH_IDLE && cmdWrite)
         next_driveIf.dirIn = ((cmdByte & OPC_RSEEK_MASK) == OPC_RSEEK) &&
                              cmdByte[BIT_RSEEK_DIR];

      // an acknowledge in the same cycle as a new end keeps the interrupt pending
      next_intPending = intSet || (intPending && !senseIntAck);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase           <= PH_IDLE;
         kind            <= CMD_NONE;
         count           <= 4'h0;
         delayTimer      <= 16'h0000;
         stepActive      <= 1'b0;
         isRecal         <= 1'b0;
         stepRemain      <= 12'h000;
         stepTimer       <= 8'h00;
         track           <= '{default: 12'h000};
         lastSector      <= 8'h00;
         stepSize        <= 8'h00;
         decided         <= 1'b0;
         diskHigher      <= 1'b0;
         sectorSt2       <= 8'h00;
         driveIf         <= '0;
         mainStatusBusy  <= 4'h0;
         intPending      <= 1'b0;
         resultStatusTwo <= 8'h00;
         scanDone        <= 1'b0;
         nextSector      <= 8'h00;
         gapLength       <= 8'h00;
      end
      else
      begin
         phase           <= next_phase;
         kind            <= next_kind;
         count           <= next_count;
         delayTimer      <= next_delayTimer;
         stepActive      <= next_stepActive;
         isRecal         <= next_isRecal;
         stepRemain      <= next_stepRemain;
         stepTimer       <= next_stepTimer;
         track           <= next_track;
         lastSector      <= next_lastSector;
         stepSize        <= next_stepSize;
         decided         <= next_decided;
         diskHigher      <= next_diskHigher;
         sectorSt2       <= next_sectorSt2;
         driveIf         <= next_driveIf;
         mainStatusBusy  <= next_mainStatusBusy;
         intPending      <= next_intPending;
         resultStatusTwo <= next_resultStatusTwo;
         scanDone        <= next_scanDone;
         nextSector      <= next_nextSector;
         gapLength       <= next_gapLength;
      end
   end

   assign cmdBusy      = (phase != PH_IDLE);
   assign presentTrack = track[driveIf.driveSel];

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   busy_set_a: assert property ((phase == PH_COLLECT) && cmdWrite &&
      (count + 4'h1 == cmdLen) && (kind == CMD_RECAL || kind == CMD_RSEEK) |=>
      mainStatusBusy[driveIf.driveSel] && phase == PH_DELAY) else $error("busy bit not set");
   delay_idle_a: assert property ((phase == PH_DELAY) && delayTimer == 16'h0000
      |=> phase == PH_IDLE && stepActive) else $error("delay end did not start stepping");
   step_poll_a: assert property (driveIf.step |-> $past(pollPhase) &&
      $past(stepActive)) else $error("step outside polling phase");
   recal_out_a: assert property (stepActive && isRecal |-> !driveIf.dirIn)
      else $error("recalibrate stepping inward");
   trk_end_a: assert property (stepActive && trackZeroInput |=> !stepActive &&
      !mainStatusBusy[driveIf.driveSel]) else $error("stepping ran past track zero");
   recal_max_a: assert property ((phase == PH_COLLECT) && cmdWrite && kind == CMD_RECAL &&
      count == 4'h1 && !modeParam2[BIT_LONG_COUNT] && !modeParam3[BIT_EXT_RANGE]
      |=> stepRemain == RECAL_MAX_DEF)
      else $error("default recalibrate count wrong");
   end_int_a: assert property ($fell(stepActive) |-> intPending)
      else $error("no interrupt at end of stepping");
   track_zero_a: assert property (stepActive && isRecal && trackZeroInput
      |=> presentTrack == 12'h000) else $error("track not cleared at track zero");
   scan_st2_a: assert property (scanDone |-> !(resultStatusTwo[ST2_SATISFIED] &&
      resultStatusTwo[ST2_NOT_SAT])) else $error("scan status both set");
endmodule

//--- testbench/floppy_drive_model.sv
// floppy drive mechanism model: head position follows the step pulses
`timescale 1ns/1ps
module floppy_drive_model (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire fdc_cmd_pkg::driveIf_t driveIf,
   input  wire logic [12:0]           startTrack,
   input  wire logic                  loadTrack,
   output logic                       trackZeroInput
);
   import fdc_cmd_pkg::*;
   logic [12:0] headPos;
   logic [12:0] next_headPos;

   // head moves one track per pulse
   always_comb
   begin
      next_headPos = headPos;
      if (loadTrack)
         next_headPos = startTrack;
      else if (driveIf.step && driveIf.dirIn)
         next_headPos = headPos + 13'h0001;
      else if (driveIf.step && headPos != 13'h0000)
         next_headPos = headPos - 13'h0001;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         headPos <= 13'h0000;
      else
         headPos <= next_headPos;
   end

   // a single head is modelled and shared by every drive the tests select
   assign trackZeroInput = (headPos == 13'h0000);
endmodule

//--- testbench/test_fdc_recal_seek_scan_cmds.sv
// testbench for the recalibrate, relative seek and scan command block
`timescale 1ns/1ps
module test_fdc_recal_seek_scan_cmds;
   import fdc_cmd_pkg::*;
   logic        clock;
   logic        rst_n;
   logic [7:0]  cmdByte;
   logic        cmdWrite;
   logic [7:0]  modeParam2;
   logic [7:0]  modeParam3;
   logic [7:0]  modeParam4;
   logic        pollPhase;
   logic        trackZeroInput;
   logic        senseIntAck;
   scanByte_t   scanIn;
   logic        transferTerminalCount;
   driveIf_t    driveIf;
   logic [3:0]  mainStatusBusy;
   logic        cmdBusy;
   logic        intPending;
   logic [11:0] presentTrack;
   logic [7:0]  resultStatusTwo;
   logic        scanDone;
   logic [7:0]  nextSector;
   logic [7:0]  gapLength;
   logic [12:0] startTrack;
   logic        loadTrack;
   logic        doneSeen;
   int          steps;
   int          err_count;
   int          samples_checked;
   logic [15:0] maxTab [4] = '{16'h0055, 16'h00FF, 16'h0F55, 16'h0FFF};
   logic [31:0] scanTab [8] = '{32'h11404008, 32'h11414004, 32'h19304000, 32'h19504004,
                                32'h19404008, 32'h1D504000, 32'h1D304004, 32'h1D404008};

   fdc_recal_seek_scan_cmds u_fdc_recal_seek_scan_cmds (
      .clock(clock), .rst_n(rst_n), .cmdByte(cmdByte), .cmdWrite(cmdWrite),
      .modeParam2(modeParam2), .modeParam3(modeParam3), .modeParam4(modeParam4),
      .delayCycles(16'h0003), .stepCycles(8'h02), .pollPhase(pollPhase),
      .trackZeroInput(trackZeroInput), .senseIntAck(senseIntAck), .scanIn(scanIn),
      .transferTerminalCount(transferTerminalCount), .driveIf(driveIf),
      .mainStatusBusy(mainStatusBusy), .cmdBusy(cmdBusy), .intPending(intPending),
      .presentTrack(presentTrack), .resultStatusTwo(resultStatusTwo),
      .scanDone(scanDone), .nextSector(nextSector), .gapLength(gapLength)
   );

   floppy_drive_model u_floppy_drive_model (
      .clock(clock), .rst_n(rst_n), .driveIf(driveIf), .startTrack(startTrack),
      .loadTrack(loadTrack), .trackZeroInput(trackZeroInput)
   );

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // pulses are counted and scan ends latched here so no single-cycle event is missed
   always @(posedge clock)
   begin
      if (driveIf.step === 1'b1)
         steps <= steps + 1;
      if (scanDone === 1'b1)
         doneSeen <= 1'b1;
   end

   task automatic end_sim;
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [7:0] b);
      @(posedge clock);
      cmdByte  <= b;
      cmdWrite <= 1'b1;
      @(posedge clock);
      cmdWrite <= 1'b0;
   endtask

   task automatic start(input logic [7:0] op, input logic [7:0] sel, input logic [7:0] n,
                        input logic [12:0] trk);
      @(posedge clock);
      startTrack <= trk;
      loadTrack  <= 1'b1;
      @(posedge clock);
      loadTrack <= 1'b0;
      steps = 0;
      put(op);
      put(sel);
      if (op != OPC_RECAL)
         put(n);
      @(posedge clock);
      #1;
      chk(mainStatusBusy[sel[1:0]], 16'h0001);
      chk({driveIf.headSel, driveIf.driveSel}, sel[2:0]);
      chk(cmdBusy, 16'h0001);
      repeat (8) @(posedge clock);
      #1;
      chk(cmdBusy, 16'h0000);
      chk(mainStatusBusy[sel[1:0]], 16'h0001);
   endtask

   task automatic finish(input logic [15:0] n, input logic dir);
      int i;
      i = 0;
      // nothing is driven until the interrupt arrives, then the acknowledge
      while (intPending !== 1'b1 && i < 15000)
      begin
         @(posedge clock);
         #1;
         i++;
      end
      chk(steps, n);
      chk(driveIf.dirIn, dir);
      chk(intPending, 16'h0001);
      chk(mainStatusBusy, 16'h0000);
      @(posedge clock);
      senseIntAck <= 1'b1;
      @(posedge clock);
      senseIntAck <= 1'b0;
      @(posedge clock);
      #1;
      chk(intPending, 16'h0000);
   endtask

   task automatic scan(input logic [7:0] op, input logic [7:0] sec, input logic [7:0] last,
                       input logic [7:0] stp);
      logic [7:0] b [9];
      b = '{op, 8'h00, 8'h00, 8'h00, sec, 8'h02, last, 8'h1B, stp};
      foreach (b[k])
         put(b[k]);
      @(posedge clock);
      #1;
      chk(gapLength, 8'h1B);
      chk(nextSector, sec);
   endtask

   task automatic feed(input logic [7:0] d, input logic [7:0] h, input logic l,
                       input logic dn);
      doneSeen = 1'b0;
      @(posedge clock);
      scanIn <= '{d, h, 1'b1, l};
      @(posedge clock);
      scanIn.valid <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk(doneSeen, dn);
   endtask

   initial
   begin
      repeat (100000) @(posedge clock);
      err_count++;
      end_sim;
   end

   initial
   begin
      rst_n = 1'b0;
      cmdByte = 8'h00;
      cmdWrite = 1'b0;
      modeParam2 = 8'h00;
      modeParam3 = 8'h00;
      modeParam4 = 8'h00;
      pollPhase = 1'b1;
      senseIntAck = 1'b0;
      scanIn = '0;
      transferTerminalCount = 1'b0;
      startTrack = 13'h0000;
      loadTrack = 1'b0;
      doneSeen = 1'b0;
      steps = 0;
      err_count = 0;
      samples_checked = 0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      // every flag pair with the head beyond every limit
      for (int m = 0; m < 4; m++)
      begin
         modeParam2 <= {7'h00, m[0]};
         modeParam3 <= {3'h0, m[1], 4'h0};
         start(OPC_RECAL, 8'h02, 8'h00, 13'h1388);
         finish(maxTab[m], 1'b0);
      end
      // the head stopped short of zero, so a second recalibrate finishes the job
      steps = 0;
      put(OPC_RECAL);
      put(8'h02);
      finish(16'h0389, 1'b0);
      // no pulses outside the polling phase
      pollPhase <= 1'b0;
      start(OPC_RECAL, 8'h06, 8'h00, 13'h0005);
      repeat (30) @(posedge clock);
      chk(steps, 16'h0000);
      pollPhase <= 1'b1;
      finish(16'h0005, 1'b0);
      chk(presentTrack, 12'h000);
      start(OPC_RSEEK, 8'h03, 8'h14, 13'h0004);
      finish(16'h0004, 1'b0);
      start(8'hCF, 8'h05, 8'h03, 13'h000A);
      finish(16'h0003, 1'b1);
      chk(presentTrack, 12'h003);
      // stored track 3 but head at 2: only the track zero input can bring it to zero
      start(OPC_RECAL, 8'h01, 8'h00, 13'h0002);
      finish(16'h0002, 1'b0);
      chk(presentTrack, 12'h000);
      // every scan type and outcome, single-sector track
      foreach (scanTab[k])
      begin
         scan(scanTab[k][31:24], 8'h03, 8'h03, 8'h01);
         feed(scanTab[k][23:16], scanTab[k][15:8], 1'b1, 1'b1);
         chk(resultStatusTwo, scanTab[k][7:0]);
      end
      // sectors advance by the step size until the last sector
      scan(OPC_SCAN_EQ, 8'h02, 8'h08, 8'h03);
      feed(8'h40, 8'h40, 1'b0, 1'b0);
      feed(8'h41, 8'h40, 1'b1, 1'b0);
      chk(nextSector, 8'h05);
      feed(8'h00, 8'h40, 1'b1, 1'b0);
      chk(nextSector, 8'h08);
      feed(8'h00, 8'h40, 1'b1, 1'b1);
      chk(resultStatusTwo, 8'h04);
      // all-ones byte from either side matches
      modeParam4 <= 8'h10;
      scan(OPC_SCAN_EQ, 8'h01, 8'h09, 8'h01);
      feed(8'hFF, 8'h12, 1'b1, 1'b1);
      chk(resultStatusTwo, 8'h08);
      scan(OPC_SCAN_EQ, 8'h01, 8'h09, 8'h01);
      feed(8'h12, 8'hFF, 1'b1, 1'b1);
      chk(resultStatusTwo, 8'h08);
      modeParam4 <= 8'h00;
      // terminal count stops a scan in mid-track
      scan(OPC_SCAN_EQ, 8'h01, 8'h09, 8'h01);
      feed(8'h55, 8'h40, 1'b1, 1'b0);
      @(posedge clock);
      transferTerminalCount <= 1'b1;
      @(posedge clock);
      transferTerminalCount <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk(doneSeen, 16'h0001);
      chk(resultStatusTwo, 8'h04);
      end_sim;
   end
endmodule
